//--- core/tm_defines.svh
`ifndef TM_DEFINES_SVH
`define TM_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define TM_IDX_STATUS 6'h00
`define TM_IDX_CONFIG 6'h01
`define TM_IDX_TEMP 6'h02
`define TM_IDX_W 6
`define TM_ADDR_LSB 2
`define TM_ADDR_MSB 7
`define TM_ADDR_W 8

// Status register fields and reset value.
`define TM_ST_LOW 4
`define TM_ST_HIGH 5
`define TM_ST_CRIT 6
`define TM_ST_RDY 7
`define TM_ST_ZERO_W 4
`define TM_ST_RESET 8'h80

// Configuration register fields and reset value.
`define TM_CF_FQ_LO 0
`define TM_CF_FQ_HI 1
`define TM_CF_CT_POL 2
`define TM_CF_INT_POL 3
`define TM_CF_CMP 4
`define TM_CF_MODE_LO 5
`define TM_CF_MODE_HI 6
`define TM_CF_RES 7
`define TM_CF_RESET 8'h00

// Data widths.
`define TM_REG_W 8
`define TM_TEMP_W 16
`define TM_HYST_W 4
`define TM_TEMP_RESET 16'h0000

// In 13-bit mode the low three bits carry the limit flags.
`define TM_MASK13 16'hfff8
`define TM_FLAG_W 3
// One degree of hysteresis is 128 LSBs of the 16-bit result.
`define TM_HYST_PAD 7'h00

// Timing: clock rate and the once-per-second period.
`define TM_CLK_KHZ 100000
`define TM_SPS_PERIOD_MS 1000
`define TM_SPS_CNT_W 27

// Alarm pin level while inactive, with the reset polarity (active low).
`define TM_PIN_IDLE 1'b1
`define TM_FQ_MAX 2'h3

`endif

//--- core/tm_pkg.sv
package tm_pkg;

	// Conversion-mode field codes.
	typedef enum logic [1:0] {
		TM_MODE_CONT = 2'h0,
		TM_MODE_ONE = 2'h1,
		TM_MODE_SPS = 2'h2,
		TM_MODE_SHUT = 2'h3
	} tm_mode_t;

	// Conversion sequencer states.
	typedef enum logic {
		TM_S_IDLE,
		TM_S_CONV
	} tm_state_t;

endpackage : tm_pkg

//--- core/tm_status_config.sv
// Decided for this implementation: the APB register port.
`include "tm_defines.svh"

// How it works
// - Status register at index 0x00 is read-only; bits 3:0 read zero.
// - Limit flags clear on status read or return inside limits.
// - Ready bit 7 resets to 1, drops on new result, rises on temp read.
// - In one-shot or 1 SPS mode a mode-field write sets ready back to 1.
// - Bit 4 sets below low limit, clears above low plus hysteresis.
// - Bit 5 sets above high limit, clears below high minus hysteresis.
// - Bit 6 sets above critical, clears below critical minus hysteresis.
// - Configuration register at index 0x01 is read/write.
// - Bits 1:0 choose one to four faults before alarms assert.
// - Bit 2 sets critical alarm pin polarity, 1 active high.
// - Bit 3 sets limit alarm pin polarity, 1 active high.
// - Bit 4 chooses latched interrupt (0) or comparator (1) behaviour.
// - Mode 00 converts continuously, next starting when one completes.
// - Mode 01 makes one conversion, then shuts down.
// - Mode 10 runs once-per-second conversions.
// - Mode 11 powers down all but the register interface.
// - Bit 7 selects 13-bit or 16-bit resolution.
// - Once-per-second mode starts one conversion each second, idle else.
// - Faults must be consecutive; an in-limit result clears the count.
// - In interrupt behaviour any register read deasserts both alarms.
module tm_status_config
	import tm_pkg::*;
#(
	parameter int SPS_PERIOD_CYC = `TM_SPS_PERIOD_MS * `TM_CLK_KHZ
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [`TM_TEMP_W-1:0] conv_result,
	output logic res_16bit,
	output logic power_down,
	input wire logic [`TM_TEMP_W-1:0] critical_limit,
	input wire logic [`TM_TEMP_W-1:0] high_limit,
	input wire logic [`TM_TEMP_W-1:0] low_limit,
	input wire logic [`TM_HYST_W-1:0] hysteresis_value,
	output logic limit_alarm_output,
	output logic critical_alarm_output
);

	localparam logic [`TM_SPS_CNT_W-1:0] SPS_LAST =
		`TM_SPS_CNT_W'(SPS_PERIOD_CYC - 1);

	logic [`TM_REG_W-1:0] cfg_q;
	logic [`TM_FLAG_W-1:0] flags_q;
	logic rdy_n_q;
	logic [`TM_TEMP_W-1:0] temp_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic conv_start_q;
	logic power_down_q;
	logic int_act_q;
	logic ct_act_q;
	logic int_pin_q;
	logic ct_pin_q;
	logic [1:0] int_cnt_q;
	logic [1:0] ct_cnt_q;
	logic one_req_q;
	logic [`TM_SPS_CNT_W-1:0] sps_cnt_q;
	tm_state_t st_q;

	logic [`TM_IDX_W-1:0] idx;
	logic hit_status;
	logic hit_config;
	logic hit_temp;
	logic mapped;
	logic acc;
	logic rd_any;
	logic rd_status;
	logic rd_temp;
	logic wr_config;
	tm_mode_t mode;
	tm_mode_t new_mode;
	logic done_ok;
	logic sps_tick;
	logic start;
	logic signed [`TM_TEMP_W:0] tv;
	logic signed [`TM_TEMP_W:0] cl;
	logic signed [`TM_TEMP_W:0] hl;
	logic signed [`TM_TEMP_W:0] ll;
	logic signed [`TM_TEMP_W:0] hy;
	logic over_crit;
	logic over_high;
	logic under_low;
	logic crit_back;
	logic high_back;
	logic low_back;
	logic int_fault;
	logic int_trip;
	logic ct_trip;
	logic [`TM_FLAG_W-1:0] flag_set;
	logic [`TM_FLAG_W-1:0] flag_back;
	logic [`TM_REG_W-1:0] status_rd;

	// Address decode; each register is one aligned 32-bit word.
	assign idx = paddr[`TM_ADDR_MSB:`TM_ADDR_LSB];
	assign hit_status = (idx == `TM_IDX_STATUS);
	assign hit_config = (idx == `TM_IDX_CONFIG);
	assign hit_temp = (idx == `TM_IDX_TEMP);
	assign mapped = hit_status || hit_config || hit_temp;

	// The access edge is the only edge on which reads and writes act.
	assign acc = psel && penable && pready_q;
	assign rd_any = acc && !pwrite && mapped;
	assign rd_status = rd_any && hit_status;
	assign rd_temp = rd_any && hit_temp;
	assign wr_config = acc && pwrite && hit_config;

	assign mode = tm_mode_t'(cfg_q[`TM_CF_MODE_HI:`TM_CF_MODE_LO]);
	assign new_mode = tm_mode_t'(pwdata[`TM_CF_MODE_HI:`TM_CF_MODE_LO]);

	// A result counts only if a conversion was actually running.
	assign done_ok = conv_done && (st_q == TM_S_CONV);

	// Status image: low nibble is unused and reads zero.
	assign status_rd = {rdy_n_q, flags_q, {`TM_ST_ZERO_W{1'b0}}};

	// Comparison operands, sign-extended to keep the hysteresis sums exact.
	// The 13-bit result ignores the three flag positions.
	always_comb
	begin
		if (cfg_q[`TM_CF_RES])
			tv = {conv_result[`TM_TEMP_W-1], conv_result};
		else
			tv = {conv_result[`TM_TEMP_W-1], conv_result & `TM_MASK13};
		cl = {critical_limit[`TM_TEMP_W-1], critical_limit};
		hl = {high_limit[`TM_TEMP_W-1], high_limit};
		ll = {low_limit[`TM_TEMP_W-1], low_limit};
		hy = {{(`TM_TEMP_W + 1 - `TM_HYST_W - 7){1'b0}},
			hysteresis_value, `TM_HYST_PAD};
	end

	// Limit tests and hysteresis release points for the newest result.
	assign over_crit = tv > cl;
	assign over_high = tv > hl;
	assign under_low = tv < ll;
	assign crit_back = tv < (cl - hy);
	assign high_back = tv < (hl - hy);
	assign low_back = tv > (ll + hy);

	// Order is status bits 4 to 6; a read clears only the flags it showed.
	assign flag_set = {3{done_ok}} & {over_crit, over_high, under_low};
	assign flag_back = ({3{done_ok}} & {crit_back, high_back, low_back})
		| ({3{rd_status}} & prdata_q[`TM_ST_CRIT:`TM_ST_LOW]);

	// Trip when this fault completes the programmed consecutive count.
	assign int_fault = over_high || under_low;
	assign int_trip = done_ok && int_fault
		&& (int_cnt_q >= cfg_q[`TM_CF_FQ_HI:`TM_CF_FQ_LO]);
	assign ct_trip = done_ok && over_crit
		&& (ct_cnt_q >= cfg_q[`TM_CF_FQ_HI:`TM_CF_FQ_LO]);

	// APB answer: pready rises in the access phase, no wait states.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			if (hit_status)
				prdata_q <= {24'h00_0000, status_rd};
			else if (hit_config)
				prdata_q <= {24'h00_0000, cfg_q};
			else if (hit_temp)
				prdata_q <= {16'h0000, temp_q};
			else
				prdata_q <= 32'h0000_0000;
		end
	end

	// Configuration register; the status and temperature words ignore writes.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cfg_q <= `TM_CF_RESET;
		else if (wr_config)
			cfg_q <= pwdata[`TM_REG_W-1:0];
	end

	// Limit flags: a fresh set beats both a status read and a release.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			flags_q <= 3'h0;
		else
			flags_q <= (flags_q & ~flag_back)
				| flag_set;
	end

	// Ready is active low; a new result wins over a read in the same cycle.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rdy_n_q <= 1'b1;
		else if (done_ok)
			rdy_n_q <= 1'b0;
		else if (rd_temp)
			rdy_n_q <= 1'b1;
		else if (wr_config && (mode == TM_MODE_ONE || mode == TM_MODE_SPS))
			rdy_n_q <= 1'b1;
	end

	// Result register; 13-bit mode puts the limit flags in the low bits.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			temp_q <= `TM_TEMP_RESET;
		else if (done_ok)
		begin
			if (cfg_q[`TM_CF_RES])
				temp_q <= conv_result;
			else
				temp_q <= {conv_result[`TM_TEMP_W-1:`TM_FLAG_W],
					over_crit, over_high, under_low};
		end
	end

	// Consecutive fault counters, saturating at three faults.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			int_cnt_q <= 2'h0;
			ct_cnt_q <= 2'h0;
		end
		else if (done_ok)
		begin
			if (!int_fault)
				int_cnt_q <= 2'h0;
			else if (int_cnt_q != `TM_FQ_MAX)
				int_cnt_q <= int_cnt_q + 2'h1;
			if (!over_crit)
				ct_cnt_q <= 2'h0;
			else if (ct_cnt_q != `TM_FQ_MAX)
				ct_cnt_q <= ct_cnt_q + 2'h1;
		end
	end

	// Limit alarm state. Interrupt behaviour latches until any read;
	// comparator behaviour follows the temperature with hysteresis.
	// A trip wins over a read so an event is never swallowed.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			int_act_q <= 1'b0;
		else if (int_trip)
			int_act_q <= 1'b1;
		else if (!cfg_q[`TM_CF_CMP] && rd_any)
			int_act_q <= 1'b0;
		else if (cfg_q[`TM_CF_CMP] && done_ok && high_back && low_back)
			int_act_q <= 1'b0;
	end

	// Critical alarm state, same behaviours as the limit alarm.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ct_act_q <= 1'b0;
		else if (ct_trip)
			ct_act_q <= 1'b1;
		else if (!cfg_q[`TM_CF_CMP] && rd_any)
			ct_act_q <= 1'b0;
		else if (cfg_q[`TM_CF_CMP] && done_ok && crit_back)
			ct_act_q <= 1'b0;
	end

	// Pin drivers apply polarity; a clear bit means active low.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			int_pin_q <= `TM_PIN_IDLE;
			ct_pin_q <= `TM_PIN_IDLE;
		end
		else
		begin
			int_pin_q <= int_act_q ~^ cfg_q[`TM_CF_INT_POL];
			ct_pin_q <= ct_act_q ~^ cfg_q[`TM_CF_CT_POL];
		end
	end

	// Each write of one-shot mode requests exactly one conversion.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			one_req_q <= 1'b0;
		else if (wr_config && new_mode == TM_MODE_ONE)
			one_req_q <= 1'b1;
		else if (start || mode != TM_MODE_ONE)
			one_req_q <= 1'b0;
	end

	// Once-per-second timer. It fires on entry to the mode, so the
	// first conversion starts at once from idle, one period later if a conversion is still running; the rest of each period is idle.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			sps_cnt_q <= '0;
		else if (mode != TM_MODE_SPS)
			sps_cnt_q <= '0;
		else if (sps_cnt_q == SPS_LAST)
			sps_cnt_q <= '0;
		else
			sps_cnt_q <= sps_cnt_q + 1'b1;
	end
	assign sps_tick = (mode == TM_MODE_SPS) && (sps_cnt_q == '0);

	// Start decision from the idle state for each mode.
	always_comb
	begin
		start = 1'b0;
		if (st_q == TM_S_IDLE)
		begin
			unique case (mode)
				TM_MODE_CONT: start = 1'b1;
				TM_MODE_ONE: start = one_req_q;
				TM_MODE_SPS: start = sps_tick;
				TM_MODE_SHUT: start = 1'b0;
			endcase
		end
	end

	// Conversion sequencer. Entering shutdown abandons a running
	// conversion; its late done pulse is then ignored.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			st_q <= TM_S_IDLE;
		else
		begin
			unique case (st_q)
				TM_S_IDLE:
					if (start)
						st_q <= TM_S_CONV;
				TM_S_CONV:
					if (conv_done || mode == TM_MODE_SHUT)
						st_q <= TM_S_IDLE;
			endcase
		end
	end

	// Converter start pulse, one cycle per conversion.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			conv_start_q <= 1'b0;
		else
			conv_start_q <= start;
	end

	// Power down the analog side in shutdown and after a one-shot.
	// The register interface stays alive in every mode.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			power_down_q <= 1'b0;
		else
			power_down_q <= (mode == TM_MODE_SHUT)
				|| (mode == TM_MODE_ONE && st_q == TM_S_IDLE
				&& !one_req_q);
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign conv_start = conv_start_q;
	assign res_16bit = cfg_q[`TM_CF_RES];
	assign power_down = power_down_q;
	assign limit_alarm_output = int_pin_q;
	assign critical_alarm_output = ct_pin_q;
endmodule : tm_status_config

//--- sim/tm_props.sv
`include "tm_defines.svh"

// Watches the register port, converter handshake and alarm pins.
module tm_props #(
	parameter int SPS_PERIOD_CYC = 200
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [`TM_TEMP_W-1:0] conv_result,
	input wire logic res_16bit,
	input wire logic power_down,
	input wire logic [`TM_TEMP_W-1:0] critical_limit,
	input wire logic [`TM_TEMP_W-1:0] high_limit,
	input wire logic [`TM_TEMP_W-1:0] low_limit,
	input wire logic [`TM_HYST_W-1:0] hysteresis_value,
	input wire logic limit_alarm_output,
	input wire logic critical_alarm_output
);
	timeunit 1ns;
	timeprecision 1ns;
	logic acc, rd, wr1, hi, crit, out;
	logic [7:0] cfg_q;
	logic [1:0] cnt_q;
	logic [1:0] ccnt_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Access decode and limit tests; limits are compared signed.
	assign acc = psel && penable && pready;
	assign rd = acc && !pwrite && paddr[7:2] < 6'h03;
	assign wr1 = acc && pwrite && paddr[7:2] == 6'h01;
	assign hi = $signed(conv_result) > $signed(high_limit);
	assign crit = $signed(conv_result) > $signed(critical_limit);
	assign out = hi || $signed(conv_result) < $signed(low_limit);

	// Shadow of the configuration, so pin levels can be predicted.
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			cfg_q <= 8'h00;
		else if (wr1)
			cfg_q <= pwdata[7:0];

	// Consecutive out-of-limit results, saturating at three.
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			cnt_q <= 2'h0;
		else if (conv_done)
			cnt_q <= !out ? 2'h0 : (cnt_q == 2'h3 ? cnt_q : cnt_q + 2'h1);

	// The critical alarm keeps its own run of consecutive faults.
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			ccnt_q <= 2'h0;
		else if (conv_done)
			ccnt_q <= !crit ? 2'h0 : (ccnt_q == 2'h3 ? ccnt_q : ccnt_q + 2'h1);

	a_status_zero: assert property (
		acc && !pwrite && paddr[7:2] == 6'h00 |-> prdata[31:8] == 24'h0
		&& prdata[3:0] == 4'h0) else $error("status unused bits set");
	a_res_follows: assert property (
		wr1 |-> ##2 res_16bit == $past(pwdata[7], 2))
		else $error("resolution output wrong");
	a_shut_power: assert property (
		wr1 && pwdata[6:5] == 2'h3 |-> ##[1:2] power_down)
		else $error("shutdown not entered");
	a_cont_restart: assert property (
		conv_done && cfg_q[6:5] == 2'h0 && !wr1 ##1 !wr1 |-> ##1 conv_start)
		else $error("continuous restart missing");
	a_read_clears: assert property (
		rd && !cfg_q[4] && !conv_done |-> ##[1:2] (limit_alarm_output !=
		cfg_q[3] && critical_alarm_output != cfg_q[2]))
		else $error("read left an alarm active");
	a_limit_trip: assert property (
		conv_done && hi && cnt_q >= cfg_q[1:0] |-> ##2
		limit_alarm_output == cfg_q[3]) else $error("limit alarm missing");
	a_crit_trip: assert property (
		conv_done && crit && ccnt_q >= cfg_q[1:0] |-> ##2
		critical_alarm_output == cfg_q[2]) else $error("crit alarm missing");
	a_queue_hold: assert property (
		conv_done && out && cnt_q < cfg_q[1:0] && limit_alarm_output !=
		cfg_q[3] |-> ##2 limit_alarm_output != cfg_q[3])
		else $error("alarm before fault count");
endmodule : tm_props

bind tm_status_config tm_props #(.SPS_PERIOD_CYC(SPS_PERIOD_CYC)) props_u (
	.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .conv_start, .conv_done, .conv_result, .res_16bit,
	.power_down, .critical_limit, .high_limit, .low_limit,
	.hysteresis_value, .limit_alarm_output, .critical_alarm_output);

//--- sim/tm_conv_model.sv
// Converter stand-in: answers each start after a settable delay.
module tm_conv_model
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic conv_start,
	input wire logic power_down,
	input wire logic [15:0] temp_in,
	input wire logic [7:0] dly,
	output logic conv_done,
	output logic [15:0] conv_result
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy_q;
	logic [7:0] cnt_q;

	// Between results the data toggles, so a stale value never matches.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			conv_done <= 1'b0;
			conv_result <= 16'h0000;
		end
		else
		begin
			conv_done <= 1'b0;
			conv_result <= ~conv_result;
			if (conv_start)
			begin
				busy_q <= 1'b1;
				cnt_q <= dly;
			end
			else if (power_down)
				busy_q <= 1'b0;
			else if (busy_q)
			begin
				cnt_q <= cnt_q - 8'h01;
				busy_q <= cnt_q != 8'h01;
				conv_done <= cnt_q == 8'h01;
				if (cnt_q == 8'h01)
					conv_result <= temp_in;
			end
		end
	end
endmodule : tm_conv_model

//--- sim/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [7:0] paddr = 8'h00, dly = 8'h3c;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, conv_start, conv_done, res_16bit, power_down;
	logic limit_alarm_output, critical_alarm_output;
	logic [15:0] conv_result, temp = 16'h1000;
	int failures, comparisons, cyc, nstart, n0;
	logic [15:0] tt [10] = '{16'h1000, 16'h3000, 16'h4800, 16'h3f80,
		16'h4800, 16'h3e00, 16'h0400, 16'h0580, 16'h0400, 16'h0700};
	logic [7:0] te [10] = '{8'h00, 8'h20, 8'hff, 8'h60, 8'hff, 8'h20,
		8'hff, 8'h10, 8'hff, 8'h00};
	logic [15:0] pt [7] = '{16'h3000, 16'h3000, 16'h1000, 16'h3000,
		16'h3000, 16'h3000, 16'h1000};
	logic [6:0] pe = 7'b0100000;

	tm_status_config #(.SPS_PERIOD_CYC(400)) dut_u (.mclk, .nrst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.conv_start, .conv_done, .conv_result, .res_16bit, .power_down,
		.critical_limit(16'h4000), .high_limit(16'h2000),
		.low_limit(16'h0500), .hysteresis_value(4'h2), .limit_alarm_output,
		.critical_alarm_output);
	tm_conv_model conv_u (.mclk, .nrst, .conv_start, .power_down,
		.temp_in(temp), .dly, .conv_done, .conv_result);

	// Free-running 100 MHz clock.
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Data is taken at the edge where pready is seen high, then released.
	task apb(input logic w, input logic [5:0] i, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wait_conv;
		while (conv_done !== 1'b1)
			@(negedge mclk);
		repeat (3) @(negedge mclk);
	endtask : wait_conv

	task stop_test;
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// Counts starts; the ceiling is far above the expected run length.
	always @(negedge mclk)
	begin
		cyc++;
		nstart += (conv_start === 1'b1);
		if (cyc == 20000)
		begin
			failures++;
			stop_test;
		end
	end

	initial
	begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b1, 6'h00, 8'h7f);
		apb(1'b0, 6'h00, 8'h00);
		chk(rd, 32'h80);
		apb(1'b0, 6'h01, 8'h00);
		chk(rd, 32'h00);
		wait_conv;
		apb(1'b0, 6'h02, 8'h00);
		chk(rd, 32'h1000);
		apb(1'b0, 6'h00, 8'h00);
		chk(rd, 32'h80);
		for (int k = 0; k < 10; k++)
		begin
			@(posedge mclk);
			temp <= tt[k];
			wait_conv;
			if (te[k] != 8'hff)
				apb(1'b0, 6'h00, 8'h00);
			if (te[k] != 8'hff)
				chk(rd, {24'h0, te[k]});
		end
		chk(critical_alarm_output, 1'b1);
		apb(1'b1, 6'h01, 8'h1e);
		dly <= 8'h09;
		apb(1'b0, 6'h01, 8'h00);
		chk(rd, 32'h1e);
		for (int k = 0; k < 7; k++)
		begin
			@(posedge mclk);
			temp <= pt[k];
			wait_conv;
			chk(limit_alarm_output, pe[k]);
		end
		chk(critical_alarm_output, 1'b0);
		apb(1'b1, 6'h01, 8'h9e);
		temp <= 16'h1005;
		dly <= 8'h3c;
		wait_conv;
		wait_conv;
		chk(res_16bit, 1'b1);
		apb(1'b0, 6'h02, 8'h00);
		chk(rd, 32'h1005);
		apb(1'b1, 6'h01, 8'h20);
		wait_conv;
		wait_conv;
		apb(1'b0, 6'h00, 8'h00);
		chk(rd, 32'h00);
		n0 = nstart;
		repeat (80) @(negedge mclk);
		chk(nstart - n0, 0);
		chk(power_down, 1'b1);
		apb(1'b1, 6'h01, 8'h20);
		apb(1'b0, 6'h00, 8'h00);
		chk(rd, 32'h80);
		wait_conv;
		n0 = nstart;
		apb(1'b1, 6'h01, 8'h40);
		repeat (1000) @(negedge mclk);
		chk(nstart - n0, 3);
		apb(1'b1, 6'h01, 8'h60);
		n0 = nstart;
		repeat (300) @(negedge mclk);
		chk(nstart - n0, 0);
		chk(power_down, 1'b1);
		apb(1'b0, 6'h01, 8'h00);
		chk(rd, 32'h60);
		apb(1'b0, 6'h05, 8'h00);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, 6'h01, 8'h00);
		wait_conv;
		chk(power_down, 1'b0);
		stop_test;
	end
endmodule : tb
